// file: design/tps_pkg.sv
// Purpose: Shared constants and types for test port pin sharing
// Assumes: Test pins are sampled by ref_clk, far slower than it (125 ns period)
// Notes:   Tap state codes, register layout and timing counts are named here
//
// What this block does
// RULE_01: Tap controller follows standard boundary-scan state walk and mode-select meaning.
// RULE_02: Scan is run through mode select, data in, clock, data out, optional reset.
// RULE_03: Two pin-sharing modes, dedicated and flexible; flexible is the default.
// RULE_04: Dedicated mode keeps clock, data-in and data-out pins away from user logic.
// RULE_05: Dedicated mode turns on pull-ups on mode-select and data-in pins.
// RULE_06: Flexible mode turns off pull-ups on mode-select and data-in pins.
// RULE_07: Tap controller steers only on mode select and test clock; resets to reset state.
// RULE_08: Flexible mode, controller in reset state: shared pins serve user I/O.
// RULE_09: Flexible mode: mode select low at first rising clock edge claims pins for test.
// RULE_10: Flexible mode: mode select high five clock cycles returns pins to user.
// RULE_11: External tester keeps mode select high when idle, low to start testing.
// RULE_12: Dedicated-or-flexible choice is static, caught once after reset.
// RULE_13: User I/O passes user data and enables; in test the tap drives data out.

package tps_pkg;

	// ************************************************************
	// Tap controller states, Gray steps along the usual walk
	// ************************************************************
	typedef enum logic [3:0] {
		TPS_TLR    = 4'h0,
		TPS_RTI    = 4'h1,
		TPS_SEL_DR = 4'h3,
		TPS_CAP_DR = 4'h2,
		TPS_SH_DR  = 4'h6,
		TPS_EX1_DR = 4'h7,
		TPS_PA_DR  = 4'h5,
		TPS_EX2_DR = 4'h4,
		TPS_UPD_DR = 4'hC,
		TPS_SEL_IR = 4'hD,
		TPS_CAP_IR = 4'hF,
		TPS_SH_IR  = 4'hE,
		TPS_EX1_IR = 4'hA,
		TPS_PA_IR  = 4'hB,
		TPS_EX2_IR = 4'h9,
		TPS_UPD_IR = 4'h8
	} tps_state_t;

	// ************************************************************
	// Instruction and data register layout
	// ************************************************************
	localparam int          IR_W        = 2;
	localparam int          DR_W        = 32;
	localparam logic [1:0]  IR_BYPASS   = 2'h3;
	localparam logic [1:0]  IR_IDCODE   = 2'h1;
	localparam logic [1:0]  IR_CAPTURE  = 2'h1;
	localparam logic [31:0] DR_RESET    = 32'h0000_0000;

	// ************************************************************
	// Timing counts
	// ************************************************************
	localparam int          SYNC_STAGES = 2;
	localparam logic [2:0]  TMS_HIGH_N  = 3'h5;
	localparam logic [2:0]  TMS_CNT_MAX = 3'h7;

endpackage : tps_pkg

// file: design/tps_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels
// Assumes: Each bit is an independent slow level
// Notes:   Only the second stage leaves this module

module tps_sync #(
	parameter int          W       = 1,
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	input  wire logic         clk,    // Sampling clock
	input  wire logic         rst_b,  // Async reset, active low
	input  wire logic [W-1:0] d,      // Asynchronous levels
	output logic      [W-1:0] q       // Synchronised levels
);

	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= RST_VAL[W-1:0];
			q       <= RST_VAL[W-1:0];
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule : tps_sync

// file: design/tps_pin_share.sv
// Purpose: Tap controller and pin-sharing logic for the shared test pins
// Assumes: Test clock is sampled by ref_clk; test pins are slow and asynchronous
// Notes:   Pad outputs and user-side inputs are registered, one cycle late

module tps_pin_share #(
	parameter logic [31:0] ID_VALUE = 32'h1234_5679,  // Arbitrary identity value
	parameter bit          HAS_TRST = 1'b1
) (
	input  wire logic ref_clk,        // Block clock, 100 MHz
	input  wire logic rst_b,          // Async reset, active low
	input  wire logic cfg_dedicated,  // Static mode choice, 1 = dedicated
	input  wire logic tms_pad_i,      // Mode select pin
	input  wire logic trst_b_pad_i,   // Optional test reset pin, active low
	input  wire logic tck_pad_i,      // Test clock pin level
	output logic      tck_pad_o,      // Test clock pin drive value
	output logic      tck_pad_oe,     // Test clock pin drive enable
	input  wire logic tdi_pad_i,      // Test data in pin level
	output logic      tdi_pad_o,      // Test data in pin drive value
	output logic      tdi_pad_oe,     // Test data in pin drive enable
	input  wire logic tdo_pad_i,      // Test data out pin level
	output logic      tdo_pad_o,      // Test data out pin drive value
	output logic      tdo_pad_oe,     // Test data out pin drive enable
	output logic      tms_pu_en,      // Mode select pull-up enable
	output logic      tdi_pu_en,      // Data in pull-up enable
	input  wire logic usr_tck_o,      // User drive value for clock pin
	input  wire logic usr_tck_oe,     // User drive enable for clock pin
	output logic      usr_tck_i,      // Clock pin level seen by user
	input  wire logic usr_tdi_o,      // User drive value for data-in pin
	input  wire logic usr_tdi_oe,     // User drive enable for data-in pin
	output logic      usr_tdi_i,      // Data-in pin level seen by user
	input  wire logic usr_tdo_o,      // User drive value for data-out pin
	input  wire logic usr_tdo_oe,     // User drive enable for data-out pin
	output logic      usr_tdo_i,      // Data-out pin level seen by user
	output logic      test_active     // Shared pins belong to the tap
);

	// ************************************************************
	// Reset release and pin synchronisers
	// ************************************************************
	logic [1:0] rst_pipe_ff;
	logic       rst_sync_b;
	logic [4:0] pins_s;
	logic       tck_s;
	logic       tms_s;
	logic       tdi_s;
	logic       trst_s;
	logic       tdo_s;
	logic       tck_d_ff;
	logic       tck_rise;
	logic       tck_fall;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe_ff <= 2'h0;
		end else begin
			rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe_ff[1];

	tps_sync #(
		.W       (5),
		.RST_VAL (32'h0000_0018)
	) u_pin_sync (
		.clk   (ref_clk),
		.rst_b (rst_sync_b),
		.d     ({trst_b_pad_i, tms_pad_i, tdo_pad_i, tdi_pad_i, tck_pad_i}),
		.q     (pins_s)
	);
	assign tck_s  = pins_s[0];
	assign tdi_s  = pins_s[1];
	assign tdo_s  = pins_s[2];
	assign tms_s  = pins_s[3];
	assign trst_s = pins_s[4] | ~HAS_TRST;

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			tck_d_ff <= 1'b0;
		end else begin
			tck_d_ff <= tck_s;
		end
	end
	assign tck_rise = tck_s & ~tck_d_ff;
	assign tck_fall = ~tck_s & tck_d_ff;

	// ************************************************************
	// Static mode capture
	// ************************************************************
	logic cfg_done_ff;
	logic dedicated_ff;
	logic nxt_cfg_done;
	logic nxt_dedicated;

	always_comb begin
		nxt_cfg_done  = 1'b1;
		nxt_dedicated = cfg_done_ff ? dedicated_ff : cfg_dedicated;  // RULE_12
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cfg_done_ff  <= 1'b0;
			dedicated_ff <= 1'b0;  // RULE_03
		end else begin
			cfg_done_ff  <= nxt_cfg_done;
			dedicated_ff <= nxt_dedicated;
		end
	end

	// ************************************************************
	// Tap controller
	// ************************************************************
	tps_pkg::tps_state_t            state_ff;
	tps_pkg::tps_state_t            nxt_state;
	logic [tps_pkg::IR_W-1:0]       ir_ff;
	logic [tps_pkg::IR_W-1:0]       nxt_ir;
	logic [tps_pkg::IR_W-1:0]       ir_sr_ff;
	logic [tps_pkg::IR_W-1:0]       nxt_ir_sr;
	logic [tps_pkg::DR_W-1:0]       dr_sr_ff;
	logic [tps_pkg::DR_W-1:0]       nxt_dr_sr;
	logic                           tdo_ff;
	logic                           nxt_tdo;
	logic                           tdo_en_ff;
	logic                           nxt_tdo_en;

	function automatic tps_pkg::tps_state_t tap_next(input tps_pkg::tps_state_t s,
		input logic m);
		case (s)
			tps_pkg::TPS_TLR:    tap_next = m ? tps_pkg::TPS_TLR    : tps_pkg::TPS_RTI;
			tps_pkg::TPS_RTI:    tap_next = m ? tps_pkg::TPS_SEL_DR : tps_pkg::TPS_RTI;
			tps_pkg::TPS_SEL_DR: tap_next = m ? tps_pkg::TPS_SEL_IR : tps_pkg::TPS_CAP_DR;
			tps_pkg::TPS_CAP_DR: tap_next = m ? tps_pkg::TPS_EX1_DR : tps_pkg::TPS_SH_DR;
			tps_pkg::TPS_SH_DR:  tap_next = m ? tps_pkg::TPS_EX1_DR : tps_pkg::TPS_SH_DR;
			tps_pkg::TPS_EX1_DR: tap_next = m ? tps_pkg::TPS_UPD_DR : tps_pkg::TPS_PA_DR;
			tps_pkg::TPS_PA_DR:  tap_next = m ? tps_pkg::TPS_EX2_DR : tps_pkg::TPS_PA_DR;
			tps_pkg::TPS_EX2_DR: tap_next = m ? tps_pkg::TPS_UPD_DR : tps_pkg::TPS_SH_DR;
			tps_pkg::TPS_UPD_DR: tap_next = m ? tps_pkg::TPS_SEL_DR : tps_pkg::TPS_RTI;
			tps_pkg::TPS_SEL_IR: tap_next = m ? tps_pkg::TPS_TLR    : tps_pkg::TPS_CAP_IR;
			tps_pkg::TPS_CAP_IR: tap_next = m ? tps_pkg::TPS_EX1_IR : tps_pkg::TPS_SH_IR;
			tps_pkg::TPS_SH_IR:  tap_next = m ? tps_pkg::TPS_EX1_IR : tps_pkg::TPS_SH_IR;
			tps_pkg::TPS_EX1_IR: tap_next = m ? tps_pkg::TPS_UPD_IR : tps_pkg::TPS_PA_IR;
			tps_pkg::TPS_PA_IR:  tap_next = m ? tps_pkg::TPS_EX2_IR : tps_pkg::TPS_PA_IR;
			tps_pkg::TPS_EX2_IR: tap_next = m ? tps_pkg::TPS_UPD_IR : tps_pkg::TPS_SH_IR;
			default:             tap_next = m ? tps_pkg::TPS_SEL_DR : tps_pkg::TPS_RTI;
		endcase
	endfunction : tap_next

	always_comb begin
		nxt_state  = state_ff;
		nxt_ir     = ir_ff;
		nxt_ir_sr  = ir_sr_ff;
		nxt_dr_sr  = dr_sr_ff;
		nxt_tdo    = tdo_ff;
		nxt_tdo_en = tdo_en_ff;
		if (!trst_s) begin
			nxt_state  = tps_pkg::TPS_TLR;  // RULE_02
			nxt_ir     = tps_pkg::IR_IDCODE;
			nxt_tdo_en = 1'b0;
		end else if (tck_rise) begin
			nxt_state = tap_next(state_ff, tms_s);  // RULE_01 RULE_07 RULE_09 RULE_10
			case (state_ff)
				tps_pkg::TPS_TLR: begin
					nxt_ir = tps_pkg::IR_IDCODE;
				end
				tps_pkg::TPS_CAP_DR: begin
					nxt_dr_sr = (ir_ff == tps_pkg::IR_IDCODE) ? ID_VALUE : tps_pkg::DR_RESET;
				end
				tps_pkg::TPS_SH_DR: begin
					if (ir_ff == tps_pkg::IR_IDCODE) begin
						nxt_dr_sr = {tdi_s, dr_sr_ff[tps_pkg::DR_W-1:1]};
					end else begin
						nxt_dr_sr = {dr_sr_ff[tps_pkg::DR_W-1:1], tdi_s};
					end
				end
				tps_pkg::TPS_CAP_IR: begin
					nxt_ir_sr = tps_pkg::IR_CAPTURE;
				end
				tps_pkg::TPS_SH_IR: begin
					nxt_ir_sr = {tdi_s, ir_sr_ff[tps_pkg::IR_W-1:1]};
				end
				tps_pkg::TPS_UPD_IR: begin
					nxt_ir = ir_sr_ff;
				end
				default: begin
					nxt_ir = ir_ff;
				end
			endcase
		end else if (tck_fall) begin
			nxt_tdo    = (state_ff == tps_pkg::TPS_SH_IR) ? ir_sr_ff[0] : dr_sr_ff[0];  // RULE_13
			nxt_tdo_en = (state_ff == tps_pkg::TPS_SH_IR) || (state_ff == tps_pkg::TPS_SH_DR);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_ff  <= tps_pkg::TPS_TLR;  // RULE_07
			ir_ff     <= tps_pkg::IR_IDCODE;
			ir_sr_ff  <= tps_pkg::IR_CAPTURE;
			dr_sr_ff  <= tps_pkg::DR_RESET;
			tdo_ff    <= 1'b0;
			tdo_en_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			ir_ff     <= nxt_ir;
			ir_sr_ff  <= nxt_ir_sr;
			dr_sr_ff  <= nxt_dr_sr;
			tdo_ff    <= nxt_tdo;
			tdo_en_ff <= nxt_tdo_en;
		end
	end

	// Dedicated pins always serve the tap; flexible ones only outside reset state
	// Strap is used live until captured, so no user cycle leaks out after reset
	assign test_active = nxt_dedicated | (state_ff != tps_pkg::TPS_TLR);  // RULE_04 RULE_08

	// ************************************************************
	// Pad and user-side outputs
	// ************************************************************
	logic [9:0] pad_ff;
	logic [9:0] nxt_pad;

	always_comb begin
		nxt_pad[0] = test_active ? 1'b0 : usr_tck_o;       // RULE_13 RULE_04
		nxt_pad[1] = test_active ? 1'b0 : usr_tck_oe;
		nxt_pad[2] = test_active ? 1'b0 : usr_tdi_o;
		nxt_pad[3] = test_active ? 1'b0 : usr_tdi_oe;
		nxt_pad[4] = test_active ? tdo_ff    : usr_tdo_o;  // RULE_13
		nxt_pad[5] = test_active ? tdo_en_ff : usr_tdo_oe;
		nxt_pad[6] = test_active ? 1'b0 : tck_s;           // RULE_08
		nxt_pad[7] = test_active ? 1'b0 : tdi_s;
		nxt_pad[8] = test_active ? 1'b0 : tdo_s;
		nxt_pad[9] = dedicated_ff;                         // RULE_05 RULE_06
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pad_ff <= 10'h000;
		end else begin
			pad_ff <= nxt_pad;
		end
	end

	assign tck_pad_o  = pad_ff[0];
	assign tck_pad_oe = pad_ff[1];
	assign tdi_pad_o  = pad_ff[2];
	assign tdi_pad_oe = pad_ff[3];
	assign tdo_pad_o  = pad_ff[4];
	assign tdo_pad_oe = pad_ff[5];
	assign usr_tck_i  = pad_ff[6];
	assign usr_tdi_i  = pad_ff[7];
	assign usr_tdo_i  = pad_ff[8];
	assign tms_pu_en  = pad_ff[9];
	assign tdi_pu_en  = pad_ff[9];

	// ************************************************************
	// Checks
	// ************************************************************
	logic [2:0] tms_hi_cnt_ff;

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			tms_hi_cnt_ff <= 3'h0;
		end else if (tck_rise && !tms_s) begin
			tms_hi_cnt_ff <= 3'h0;
		end else if (tck_rise && tms_hi_cnt_ff != tps_pkg::TMS_CNT_MAX) begin
			tms_hi_cnt_ff <= tms_hi_cnt_ff + 3'h1;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_sync_b);

	a_ded_pins_test: assert property (nxt_dedicated |=> !tck_pad_oe && !tdi_pad_oe // RULE_04
		&& !usr_tck_i && !usr_tdi_i && !usr_tdo_i)
		else $error("dedicated mode released shared pins");
	a_ded_pullup_on: assert property (dedicated_ff |=> tms_pu_en && tdi_pu_en) // RULE_05
		else $error("pull-ups off in dedicated mode");
	a_flex_pullup_off: assert property (!dedicated_ff |=> !tms_pu_en && !tdi_pu_en) // RULE_06
		else $error("pull-ups on in flexible mode");
	a_tlr_user_io: assert property (cfg_done_ff && !dedicated_ff // RULE_08
		&& state_ff == tps_pkg::TPS_TLR
		|=> usr_tck_i == $past(tck_s) && usr_tdi_i == $past(tdi_s) && usr_tdo_i == $past(tdo_s))
		else $error("reset state did not give pins to user");
	a_tms_low_enter: assert property (!dedicated_ff && state_ff == tps_pkg::TPS_TLR // RULE_09
		&& tck_rise && !tms_s && trst_s |=> test_active ##1 !tck_pad_oe)
		else $error("low mode select did not claim pins");
	a_five_high_tlr: assert property (tck_rise && tms_s && trst_s // RULE_10
		&& tms_hi_cnt_ff >= (tps_pkg::TMS_HIGH_N - 3'h1) |=> state_ff == tps_pkg::TPS_TLR)
		else $error("five high cycles did not reach reset state");
	a_reset_enters_tlr: assert property (!trst_s |=> state_ff == tps_pkg::TPS_TLR) // RULE_07
		else $error("test reset did not reach reset state");
	a_mode_static: assert property (cfg_done_ff |=> $stable(dedicated_ff)) // RULE_12
		else $error("pin-sharing mode changed after capture");
	a_user_pass: assert property (cfg_done_ff && !test_active // RULE_13
		|=> tdo_pad_o == $past(usr_tdo_o) && tdo_pad_oe == $past(usr_tdo_oe))
		else $error("user data not passed to data-out pin");
	a_tdo_shift_drv: assert property (test_active && tdo_en_ff |=> tdo_pad_oe) // RULE_13
		else $error("tap did not drive data out while shifting");
	a_tap_walk: assert property (tck_rise && trst_s && state_ff == tps_pkg::TPS_SEL_IR // RULE_01
		&& tms_s |=> state_ff == tps_pkg::TPS_TLR)
		else $error("tap walk from select-ir wrong");

	c_enter_test: cover property (!test_active ##1 test_active);
	c_return_user: cover property (test_active && !dedicated_ff ##1 !test_active);
	c_shift_dr: cover property (state_ff == tps_pkg::TPS_SH_DR && tck_rise);
	c_update_ir: cover property (state_ff == tps_pkg::TPS_UPD_IR && tck_rise);

endmodule : tps_pin_share

// file: tb/tps_tester.sv
// Purpose: Behavioural boundary-scan tester driving the shared test pins
// Assumes: Test clock period of 125 ns, standing low between frames
// Notes:   Mode select and data in change just after each falling clock edge

module tps_tester (
	output logic      tms,     // Mode select
	output logic      tck,     // Test clock
	output logic      tdi,     // Test data in
	output logic      trst_b,  // Test reset, active low
	input  wire logic tdo      // Test data out level
);
	timeunit 1ns;
	timeprecision 100ps;

	// ********************
	// Pin driving
	// ********************
	real lo_extra;

	initial begin
		lo_extra = 0.0;
		tms      = 1'b1;
		tck      = 1'b0;
		tdi      = 1'b1;
		trst_b   = 1'b1;
	end

	// Extra low time turns this into a slow tester
	task step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#(62.5 + lo_extra);
		o   = tdo;
		tck = 1'b1;
		#62.5;
		tck = 1'b0;
	endtask : step

	task test_reset();
		trst_b = 1'b0;
		#100;
		trst_b = 1'b1;
	endtask : test_reset

endmodule : tps_tester

// file: tb/tps_pin_share_bench.sv
// Purpose: Self-checking bench for the test pin sharing block
// Assumes: Tester model owns mode select, test clock, data in and test reset
// Notes:   Pin levels resolve from the block's enables, tester and a noisy float

module tps_pin_share_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ********************
	// Signals
	// ********************
	localparam logic [31:0] ID_V = 32'h5A5A_C3C3;  // Arbitrary identity value

	logic        ref_clk;
	logic        rst_b;
	logic        cfg_dedicated;
	logic        tms;
	logic        tck_t;
	logic        tdi_t;
	logic        trst_b;
	logic        tdo_float;
	logic [2:0]  pin;
	logic [2:0]  pad_o;
	logic [2:0]  pad_oe;
	logic [2:0]  usr_o;
	logic [2:0]  usr_oe;
	logic [2:0]  usr_i;
	logic        tms_pu_en;
	logic        tdi_pu_en;
	logic        test_active;
	logic        tv;
	logic [31:0] sh;
	int          errors;
	int          checks_done;

	// Undriven data-out pin shows a changing pattern
	assign pin[2] = pad_oe[2] ? pad_o[2] : tck_t;
	assign pin[1] = pad_oe[1] ? pad_o[1] : tdi_t;
	assign pin[0] = pad_oe[0] ? pad_o[0] : tdo_float;

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) tdo_float <= ~tdo_float;

	tps_pin_share #(.ID_VALUE(ID_V), .HAS_TRST(1'b1)) u_tps_pin_share (
		.ref_clk(ref_clk), .rst_b(rst_b), .cfg_dedicated(cfg_dedicated),
		.tms_pad_i(tms), .trst_b_pad_i(trst_b), .tck_pad_i(pin[2]),
		.tck_pad_o(pad_o[2]), .tck_pad_oe(pad_oe[2]), .tdi_pad_i(pin[1]),
		.tdi_pad_o(pad_o[1]), .tdi_pad_oe(pad_oe[1]), .tdo_pad_i(pin[0]),
		.tdo_pad_o(pad_o[0]), .tdo_pad_oe(pad_oe[0]),
		.tms_pu_en(tms_pu_en), .tdi_pu_en(tdi_pu_en),
		.usr_tck_o(usr_o[2]), .usr_tck_oe(usr_oe[2]), .usr_tck_i(usr_i[2]),
		.usr_tdi_o(usr_o[1]), .usr_tdi_oe(usr_oe[1]), .usr_tdi_i(usr_i[1]),
		.usr_tdo_o(usr_o[0]), .usr_tdo_oe(usr_oe[0]), .usr_tdo_i(usr_i[0]),
		.test_active(test_active)
	);

	tps_tester u_tps_tester (
		.tms(tms), .tck(tck_t), .tdi(tdi_t), .trst_b(trst_b), .tdo(pin[0])
	);

	// ********************
	// Helpers
	// ********************
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_clk

	// One test clock cycle; data out samples gather LSB first
	task st(input logic m, input logic d);
		u_tps_tester.step(m, d, tv);
		sh = {tv, sh[31:1]};
	endtask : st

	task do_reset(input logic ded);
		@(posedge ref_clk);
		#1;
		rst_b         = 1'b0;
		cfg_dedicated = ded;
		wait_clk(3);
		rst_b = 1'b1;
		wait_clk(8);
	endtask : do_reset

	task wrap_up();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ********************
	// Scenarios
	// ********************
	task t_user();
		chk("test_active", test_active, 1'b0);
		chk("pull_ups", {tms_pu_en, tdi_pu_en}, 2'b00);
		usr_o  = 3'h5;
		usr_oe = 3'h7;
		wait_clk(8);
		chk("pad_o", pad_o, 3'h5);
		chk("pad_oe", pad_oe, 3'h7);
		chk("usr_i", usr_i, 3'h5);
		usr_o = 3'h2;
		wait_clk(8);
		chk("usr_i", usr_i, 3'h2);
		usr_oe = 3'h0;
		wait_clk(8);
		chk("pad_oe", pad_oe, 3'h0);
		chk("usr_i", usr_i[2:1], 2'b01);
		st(1'b1, 1'b1);
		st(1'b1, 1'b1);
		chk("test_active", test_active, 1'b0);
		$display("t_user done");
	endtask : t_user

	task t_enter();
		usr_o  = 3'h7;
		usr_oe = 3'h1;
		wait_clk(8);
		chk("pad_oe", pad_oe, 3'h1);
		st(1'b0, 1'b1);
		chk("test_active", test_active, 1'b1);
		chk("pad_oe", pad_oe, 3'h0);
		chk("usr_i", usr_i, 3'h0);
		$display("t_enter done");
	endtask : t_enter

	task t_idcode();
		st(1'b1, 1'b0);
		st(1'b0, 1'b0);
		st(1'b0, 1'b0);
		for (int i = 0; i < 32; i++) begin
			st(i == 31, 1'b0);
			if (i == 0) chk("pad_oe", pad_oe, 3'h1);
		end
		chk("idcode", sh, ID_V);
		repeat (3) st(1'b1, 1'b0);
		chk("held", test_active, 1'b1);
		st(1'b1, 1'b0);
		wait_clk(2);
		chk("released", test_active, 1'b0);
		chk("pad_oe", pad_oe, 3'h1);
		$display("t_idcode done");
	endtask : t_idcode

	// Load bypass with a slow tester, then a one-bit data path
	task t_bypass();
		logic [13:0] tm;
		logic [13:0] td;
		tm = 14'b01100011100001;
		td = 14'b11111110000100;
		u_tps_tester.lo_extra = 40.0;
		for (int i = 13; i >= 0; i--) st(tm[i], td[i]);
		chk("ir_capture", sh[24:23], 2'b01);
		chk("bypass", sh[31:29], 3'b010);
		repeat (4) st(1'b1, 1'b0);
		u_tps_tester.lo_extra = 0.0;
		wait_clk(2);
		chk("test_active", test_active, 1'b0);
		$display("t_bypass done");
	endtask : t_bypass

	task t_trst();
		st(1'b0, 1'b1);
		chk("test_active", test_active, 1'b1);
		u_tps_tester.test_reset();
		wait_clk(2);
		chk("test_active", test_active, 1'b0);
		$display("t_trst done");
	endtask : t_trst

	task t_dedicated();
		do_reset(1'b1);
		usr_oe = 3'h7;
		wait_clk(8);
		chk("pull_ups", {tms_pu_en, tdi_pu_en}, 2'b11);
		chk("test_active", test_active, 1'b1);
		chk("pad_oe", pad_oe, 3'h0);
		chk("usr_i", usr_i, 3'h0);
		cfg_dedicated = 1'b0;
		repeat (5) st(1'b1, 1'b1);
		chk("pull_ups", {tms_pu_en, tdi_pu_en}, 2'b11);
		chk("test_active", test_active, 1'b1);
		$display("t_dedicated done");
	endtask : t_dedicated

	// ********************
	// Main sequence
	// ********************
	initial begin
		ref_clk       = 1'b0;
		rst_b         = 1'b0;
		cfg_dedicated = 1'b0;
		tdo_float     = 1'b0;
		usr_o         = 3'h0;
		usr_oe        = 3'h0;
		sh            = 32'h0000_0000;
		errors        = 0;
		checks_done   = 0;
		do_reset(1'b0);
		t_user();
		t_enter();
		t_idcode();
		t_bypass();
		t_trst();
		t_dedicated();
		wrap_up();
	end

	initial begin
		#200us;
		errors++;
		wrap_up();
	end

endmodule : tps_pin_share_bench
